// ### rtl/gsc_pin_mux.sv
`timescale 1ns/10ps
`include "gsc_consts.svh"
module gsc_pin_mux
  import gsc_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  reg_wr,
  input  wire logic [15:0]                           reg_addr,
  input  wire logic [15:0]                           reg_wdata,
  output logic      [15:0]                           reg_rdata,
  input  wire logic [`GSC_NUM_SRC-1:0]               src_tick,
  input  wire logic [1:0]                            pwm_in,
  input  wire logic                                  in_detect,
  input  wire logic [1:0]                            us_detect,
  input  wire logic [`GSC_NUM_ALARM-1:0]             alarm_trig,
  input  wire logic [`GSC_NUM_ALARM-1:0]             alarm_cyclic,
  input  wire logic [`GSC_NUM_ALARM-1:0]             alarm_arm,
  input  wire logic [`GSC_ALM_LEN_W-1:0]             alarm_len,
  input  wire logic [`GSC_NUM_PINS*`GSC_FN_W-1:0]    pin_function_select,
  input  wire logic [`GSC_NUM_PINS-1:0]              pin_output_invert,
  output logic      [`GSC_NUM_PINS-1:0]              pin_out,
  output logic      [`GSC_NUM_PINS-1:0]              pin_claim,
  output logic                                       divided_output_clock,
  input  wire logic [`GSC_IRQ_W-1:0]                 irq_clear,
  output logic      [`GSC_IRQ_W-1:0]                 irq_status,
  output logic                                       irq_any
);

  logic [15:0]                 ctrl_ff;
  logic [15:0]                 nxt_ctrl;
  logic [15:0]                 rdata_ff;
  logic [15:0]                 nxt_rdata;
  logic                        sel_tick;
  logic [2:0]                  det_prev_ff;
  logic [2:0]                  nxt_det_prev;
  logic [`GSC_IRQ_W-1:0]       irq_ff;
  logic [`GSC_IRQ_W-1:0]       nxt_irq;
  logic [`GSC_IRQ_W-1:0]       irq_evt;
  logic [`GSC_NUM_ALARM-1:0]   alm_armed_ff;
  logic [`GSC_NUM_ALARM-1:0]   nxt_alm_armed;
  logic [`GSC_NUM_ALARM-1:0]   alm_fire;
  logic [`GSC_NUM_ALARM-1:0]   alm_act;
  logic [`GSC_ALM_LEN_W-1:0]   alm_cnt_ff  [`GSC_NUM_ALARM];
  logic [`GSC_ALM_LEN_W-1:0]   nxt_alm_cnt [`GSC_NUM_ALARM];
  logic [`GSC_NUM_PINS-1:0]    pin_ff;
  logic [`GSC_NUM_PINS-1:0]    nxt_pin;
  logic [`GSC_NUM_PINS-1:0]    claim_ff;
  logic [`GSC_NUM_PINS-1:0]    nxt_claim;
  logic [2:0]                  det_cur;

  gsc_clk_if cif ();

  // Control register: only the enable, divider and select bits store
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_rdata = 16'h0000;
    if (reg_wr && reg_addr == `GSC_REG_OUT_CLK_CTRL) begin
      nxt_ctrl = reg_wdata & `GSC_CTRL_WR_MASK;
    end
    if (reg_addr == `GSC_REG_OUT_CLK_CTRL) begin
      nxt_rdata = ctrl_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff  <= `GSC_CTRL_RESET;
      rdata_ff <= 16'h0000;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // The clock tree supplies ticks at the 48 kHz or 44.1 kHz family rate
  // that matches the running system clock; reserved codes stop the ticks
  always_comb begin
    sel_tick = 1'b0;
    if (!ctrl_ff[`GSC_SEL_MSB]) begin
      sel_tick = src_tick[ctrl_ff[`GSC_SEL_LSB+1:`GSC_SEL_LSB]];
    end
  end

  assign cif.enable   = ctrl_ff[`GSC_EN_BIT];
  assign cif.divider  = ctrl_ff[`GSC_DIV_MSB:`GSC_DIV_LSB];
  assign cif.src_tick = sel_tick;
  assign divided_output_clock = cif.clk_out;

  gsc_clk_div u_clk_div (
    .clk (clk),
    .rst (rst),
    .cif (cif)
  );

  // Detect edges and alarm channels
  assign det_cur = {us_detect, in_detect};

  always_comb begin
    nxt_det_prev  = det_cur;
    nxt_alm_armed = alm_armed_ff | alarm_arm;
    irq_evt       = '0;
    for (int c = 0; c < 3; c++) begin
      irq_evt[2*c]   = det_cur[c] & ~det_prev_ff[c];
      irq_evt[2*c+1] = ~det_cur[c] & det_prev_ff[c];
    end
    for (int a = 0; a < `GSC_NUM_ALARM; a++) begin
      alm_fire[a]    = alarm_trig[a] & (alarm_cyclic[a] | alm_armed_ff[a]);
      nxt_alm_cnt[a] = alm_cnt_ff[a];
      if (alm_fire[a]) begin
        // A zero length still gives one cycle so the event is visible
        nxt_alm_cnt[a] = (alarm_len == '0) ? 8'h01 : alarm_len;
        if (!alarm_cyclic[a]) begin
          nxt_alm_armed[a] = 1'b0;
        end
      end else if (alm_cnt_ff[a] != '0) begin
        nxt_alm_cnt[a] = alm_cnt_ff[a] - 8'h01;
      end
      irq_evt[`GSC_IRQ_ALM_BASE+a] = alm_fire[a];
    end
    // Set wins over a clear in the same cycle
    nxt_irq = (irq_ff & ~irq_clear) | irq_evt;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_prev_ff  <= 3'h0;
      alm_armed_ff <= '1;
      irq_ff       <= '0;
      for (int a = 0; a < `GSC_NUM_ALARM; a++) begin
        alm_cnt_ff[a] <= '0;
      end
    end else begin
      det_prev_ff  <= nxt_det_prev;
      alm_armed_ff <= nxt_alm_armed;
      irq_ff       <= nxt_irq;
      for (int a = 0; a < `GSC_NUM_ALARM; a++) begin
        alm_cnt_ff[a] <= nxt_alm_cnt[a];
      end
    end
  end

  always_comb begin
    for (int a = 0; a < `GSC_NUM_ALARM; a++) begin
      alm_act[a] = (alm_cnt_ff[a] != '0);
    end
  end

  assign irq_status = irq_ff;
  assign irq_any    = |irq_ff;

  // Pin selection; unknown codes release the pin to other functions
  always_comb begin
    logic [`GSC_FN_W-1:0] fn;
    logic                 lvl;
    logic                 hit;
    fn  = '0;
    lvl = 1'b0;
    hit = 1'b0;
    for (int p = 0; p < `GSC_NUM_PINS; p++) begin
      fn  = pin_function_select[p*`GSC_FN_W +: `GSC_FN_W];
      hit = 1'b1;
      case (fn)
        GSC_FN_OUTCLK: lvl = cif.clk_out;
        GSC_FN_PWM0:   lvl = pwm_in[0];
        GSC_FN_PWM1:   lvl = pwm_in[1];
        GSC_FN_INDET:  lvl = in_detect;
        GSC_FN_US0:    lvl = us_detect[0];
        GSC_FN_US1:    lvl = us_detect[1];
        GSC_FN_ALM0:   lvl = alm_act[0];
        GSC_FN_ALM1:   lvl = alm_act[1];
        GSC_FN_ALM2:   lvl = alm_act[2];
        GSC_FN_ALM3:   lvl = alm_act[3];
        default: begin
          lvl = 1'b0;
          hit = 1'b0;
        end
      endcase
      nxt_pin[p]   = hit & (lvl ^ pin_output_invert[p]);
      nxt_claim[p] = hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_ff   <= '0;
      claim_ff <= '0;
    end else begin
      pin_ff   <= nxt_pin;
      claim_ff <= nxt_claim;
    end
  end

  assign pin_out   = pin_ff;
  assign pin_claim = claim_ff;

  AST_PIN_OUTCLK:
    assert property (@(posedge clk) disable iff (rst)
      (pin_function_select[10:0] == 11'h048 && !pin_output_invert[0])
      |=> pin_out[0] == $past(divided_output_clock))
    else $error("pin 0 does not follow the output clock");

  AST_EN_GATES_CLOCK:
    assert property (@(posedge clk) disable iff (rst)
      (!ctrl_ff[15]) [*2] |-> !divided_output_clock)
    else $error("output clock runs while enable is clear");

  AST_RESERVED_SEL:
    assert property (@(posedge clk) disable iff (rst)
      ctrl_ff[2] |-> !sel_tick)
    else $error("reserved source select still ticks");

  AST_SEL_HIGHEST:
    assert property (@(posedge clk) disable iff (rst)
      ctrl_ff[2:0] == 3'h3 |-> sel_tick == src_tick[3])
    else $error("select code 3 does not use source 3");

  AST_PIN_PWM:
    assert property (@(posedge clk) disable iff (rst)
      (pin_function_select[10:0] == 11'h081 && !pin_output_invert[0])
      |=> pin_out[0] == $past(pwm_in[1]))
    else $error("pin 0 does not follow the second PWM");

  AST_PIN_DETECT_INV:
    assert property (@(posedge clk) disable iff (rst)
      (pin_function_select[10:0] == 11'h08c && pin_output_invert[0])
      |=> pin_out[0] == !$past(in_detect))
    else $error("inverted detect level wrong on pin 0");

  AST_US_FALL_IRQ:
    assert property (@(posedge clk) disable iff (rst)
      (!us_detect[0] && det_prev_ff[1]) |=> irq_status[3])
    else $error("ultrasonic falling edge not latched");

  AST_IRQ_STICKY:
    assert property (@(posedge clk) disable iff (rst)
      (irq_status[0] && !irq_clear[0]) |=> irq_status[0])
    else $error("rise interrupt bit dropped without a clear");

  AST_ALARM_LEN:
    assert property (@(posedge clk) disable iff (rst)
      (alarm_trig[0] && (alarm_cyclic[0] || alm_armed_ff[0])
       && alarm_len == 8'h03)
      |=> alm_act[0] [*3])
    else $error("alarm 0 shorter than its length");

  AST_ONE_OFF:
    assert property (@(posedge clk) disable iff (rst)
      (alarm_trig[0] && !alarm_cyclic[0] && !alm_armed_ff[0]
       && !irq_status[6] && !irq_clear[6])
      |=> !irq_status[6])
    else $error("one-off alarm fired twice");

  AST_ALARM_IRQ:
    assert property (@(posedge clk) disable iff (rst)
      (alarm_trig[1] && (alarm_cyclic[1] || alm_armed_ff[1]))
      |=> irq_status[7] ##0 irq_any)
    else $error("alarm 1 trigger did not latch its interrupt");

endmodule

// ### rtl/gsc_consts.svh
// Summary of operation
// - Function code 0x048 puts output clock on pin
// - Bit 15 enables the output clock
// - Bits 7:3 divide source by even code
// - Bits 2:0 pick one of four sources
// - 44.1 kHz family gives the bracketed rates
// - Codes 0x080/0x081 route the two PWM outputs
// - Code 0x08C routes the input detect flag
// - Codes 0x090/0x092 route ultrasonic detect flags
// - Detect edges set latched rise/fall interrupt bits
// - Codes 0x230-0x233 route alarms, configurable length
// - Alarm channels run one-off or cyclic
// - Each armed or cyclic alarm trigger latches its interrupt bit
// - Invert bit flips the selected pin level
`ifndef GSC_CONSTS_SVH
`define GSC_CONSTS_SVH

`define GSC_REG_OUT_CLK_CTRL 16'h1020
`define GSC_CTRL_RESET       16'h0000
`define GSC_CTRL_WR_MASK     16'h80ff
`define GSC_EN_BIT           15
`define GSC_DIV_MSB          7
`define GSC_DIV_LSB          3
`define GSC_SEL_MSB          2
`define GSC_SEL_LSB          0
`define GSC_NUM_PINS         16
`define GSC_FN_W             11
`define GSC_NUM_SRC          4
`define GSC_NUM_ALARM        4
`define GSC_ALM_LEN_W        8
`define GSC_IRQ_W            10
`define GSC_IRQ_IN_RISE      0
`define GSC_IRQ_IN_FALL      1
`define GSC_IRQ_US_BASE      2
`define GSC_IRQ_ALM_BASE     6

`endif

// ### rtl/gsc_pkg.sv
package gsc_pkg;

  typedef enum logic [10:0] {
    GSC_FN_OUTCLK = 11'h048,
    GSC_FN_PWM0   = 11'h080,
    GSC_FN_PWM1   = 11'h081,
    GSC_FN_INDET  = 11'h08c,
    GSC_FN_US0    = 11'h090,
    GSC_FN_US1    = 11'h092,
    GSC_FN_ALM0   = 11'h230,
    GSC_FN_ALM1   = 11'h231,
    GSC_FN_ALM2   = 11'h232,
    GSC_FN_ALM3   = 11'h233
  } gsc_fn_t;

  typedef logic [4:0] gsc_div_t;
  typedef logic [3:0] gsc_half_t;

  // Half period in source ticks; reserved codes below 2 act as 2
  function automatic gsc_half_t gsc_half(input gsc_div_t div);
    gsc_half_t h;
    h = div[4:1];
    if (h == 4'h0) begin
      h = 4'h1;
    end
    return h;
  endfunction

endpackage

// ### rtl/gsc_clk_if.sv
`timescale 1ns/10ps
interface gsc_clk_if;
  logic       enable;
  logic [4:0] divider;
  logic       src_tick;
  logic       clk_out;

  modport gen (input enable, input divider, input src_tick,
               output clk_out);
  modport ctl (output enable, output divider, output src_tick,
               input clk_out);
endinterface

// ### rtl/gsc_clk_div.sv
`timescale 1ns/10ps
`include "gsc_consts.svh"
module gsc_clk_div
  import gsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  gsc_clk_if.gen   cif
);

  gsc_half_t cnt_ff;
  gsc_half_t nxt_cnt;
  logic      out_ff;
  logic      nxt_out;
  gsc_half_t half;

  always_comb begin
    half    = gsc_half(cif.divider);
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    if (!cif.enable) begin
      nxt_cnt = 4'h0;
      nxt_out = 1'b0;
    end else if (cif.src_tick) begin
      // Compare with >= so a divider change mid-run cannot hang the count
      if (cnt_ff >= half - 4'h1) begin
        nxt_cnt = 4'h0;
        nxt_out = ~out_ff;
      end else begin
        nxt_cnt = cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign cif.clk_out = out_ff;

  AST_CLK_LOW_DISABLED:
    assert property (@(posedge clk) disable iff (rst)
      !cif.enable |=> !cif.clk_out)
    else $error("output clock not low while disabled");

  AST_CLK_TOGGLE_ON_TICK:
    assert property (@(posedge clk) disable iff (rst)
      ($changed(cif.clk_out) && $past(cif.enable)) |-> $past(cif.src_tick))
    else $error("output clock changed without a source tick");

  AST_DIV4_HALF:
    assert property (@(posedge clk) disable iff (rst)
      (cif.enable && cif.divider == 5'h04 && cif.src_tick
       && cnt_ff == 4'h0 && $stable(cif.divider))
      |=> $stable(cif.clk_out))
    else $error("divide by 4 toggled after one tick");

endmodule

// ### test/gsc_pin_load.sv
`timescale 1ns/10ps
// External load on one pin: counts rising edges it sees
module gsc_pin_load (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pin,
  output logic      [15:0] rise_cnt
);
  logic        last_ff;
  logic [15:0] cnt_ff;
  // A real load only sees the wire, so nothing but the pin is watched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_ff <= 1'b0;
      cnt_ff  <= 16'h0000;
    end else begin
      last_ff <= pin;
      if (pin && !last_ff) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
  assign rise_cnt = cnt_ff;
endmodule

// ### test/gsc_pin_mux_tb.sv
`timescale 1ns/10ps
`include "gsc_consts.svh"
module gsc_pin_mux_tb;
  import gsc_pkg::*;
  logic         clk, rst, reg_wr, in_detect, divided_output_clock, irq_any;
  logic [15:0]  reg_addr, reg_wdata, reg_rdata, pin_out, pin_claim, v, rises;
  logic [15:0]  pin_output_invert;
  logic [15:0]  r0;
  logic [3:0]   src_tick, alarm_trig, alarm_cyclic, alarm_arm;
  logic [1:0]   pwm_in, us_detect;
  logic [7:0]   alarm_len;
  logic [175:0] pin_function_select;
  logic [9:0]   irq_clear, irq_status;
  logic [10:0]  c;
  logic         e;
  int           n_mismatch, check_count, i, k, p;
  logic [10:0]  codes [9] = '{11'h080, 11'h081, 11'h08c, 11'h090, 11'h092,
                              11'h048, 11'h230, 11'h233, 11'h7ff};

  gsc_pin_mux uut (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .src_tick, .pwm_in, .in_detect, .us_detect, .alarm_trig, .alarm_cyclic,
    .alarm_arm, .alarm_len, .pin_function_select, .pin_output_invert,
    .pin_out, .pin_claim, .divided_output_clock, .irq_clear, .irq_status,
    .irq_any);
  gsc_pin_load pl (.clk(clk), .rst(rst), .pin(pin_out[1]), .rise_cnt(rises));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic claim(input logic [10:0] f);
    return f inside {11'h048, 11'h080, 11'h081, 11'h08c, 11'h090, 11'h092,
                     [11'h230:11'h233]};
  endfunction

  function automatic logic lvl(input logic [10:0] f);
    case (f)
      11'h080: return pwm_in[0];
      11'h081: return pwm_in[1];
      11'h08c: return in_detect;
      11'h090: return us_detect[0];
      11'h092: return us_detect[1];
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string m);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    n_mismatch++;
    summarize();
  end

  initial begin
    {rst, reg_wr, in_detect, src_tick, alarm_trig, alarm_cyclic} = '1;
    {reg_wr, in_detect, src_tick, alarm_trig, alarm_cyclic} = '0;
    {reg_addr, reg_wdata, pin_output_invert, pwm_in, us_detect} = '0;
    {alarm_arm, alarm_len, pin_function_select, irq_clear} = '0;
    i = $urandom(20);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(16'h1020, v);
    chk(v, 16'h0000, "ctrl reset");
    wr(16'h1020, 16'h7f00);
    rd(16'h1020, v);
    chk(v, 16'h0000, "bits 14:8 read 0");
    wr(16'h1022, 16'hffff);
    rd(16'h1022, v);
    chk(v, 16'h0000, "unmapped read");
    rd(16'h1020, v);
    chk(v, 16'h0000, "unmapped write leaked");
    // Mux table: eight handled codes (not 0x231/0x232), an unknown one, then random codes
    for (k = 0; k < 40; k++) begin
      c = (k < 9) ? codes[k] : 11'($urandom);
      p = $urandom_range(15);
      @(posedge clk);
      pin_function_select[p*11+:11] <= c;
      pin_output_invert[p] <= 1'($urandom);
      {pwm_in, us_detect, in_detect} <= 5'($urandom);
      irq_clear <= 10'h3ff;
      step(1);
      e = claim(c) ? lvl(c) ^ pin_output_invert[p] : 1'b0;
      chk(pin_out[p], e, "pin level");
      chk(pin_claim[p], claim(c), "pin claim");
    end
    // Hold the clear while the last random detect level settles
    in_detect <= 1'b0;
    pin_function_select <= '0;
    pin_output_invert <= '0;
    step(2);
    irq_clear <= 10'h000;
    step(1);
    // Detect edges latch separate rise and fall bits
    in_detect <= 1'b1;
    step(1);
    chk(irq_status[1:0], 2'b01, "rise irq");
    in_detect <= 1'b0;
    step(3);
    chk(irq_status[1:0], 2'b11, "fall irq, rise held");
    chk(irq_any, 1'b1, "irq any");
    irq_clear <= 10'h3ff;
    step(1);
    irq_clear <= 10'h000;
    step(1);
    chk(irq_status, 10'h000, "irq clear");
    // Output clock: divide by 6 from source 0, enable set last
    pin_function_select[1*11+:11] <= 11'h048;
    wr(16'h1020, 16'h0030);
    wr(16'h1020, 16'h8030);
    rd(16'h1020, v);
    chk(v, 16'h8030, "ctrl readback");
    r0 = rises;
    for (i = 1; i <= 15; i++) begin
      @(posedge clk);
      src_tick <= {3'($urandom), 1'b1};
      @(posedge clk);
      src_tick <= 4'h0;
      #1 chk(divided_output_clock, (i / 3) % 2, "div clk");
      step(1);
      chk(pin_out[1], (i / 3) % 2, "clk on pin");
    end
    wr(16'h1020, 16'h0030);
    step(1);
    chk(divided_output_clock, 1'b0, "clk low when off");
    chk(rises - r0, 16'h0003, "clk rises at load");
    // Source 3 at divide by 4; ticks of the other sources must not count
    wr(16'h1020, 16'h0023);
    wr(16'h1020, 16'h8023);
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      src_tick <= (i % 2) ? 4'h8 : 4'h7;
      @(posedge clk);
      src_tick <= 4'h0;
      #1 chk(divided_output_clock, (i + 1) / 4 % 2, "sel 3 div 4");
    end
    // Alarms: one-off channel 0 on pin 2, cyclic channel 1 on pin 3
    pin_function_select[2*11+:11] <= 11'h230;
    pin_function_select[3*11+:11] <= 11'h231;
    alarm_cyclic <= 4'h2;
    alarm_len <= 8'h03;
    for (k = 0; k < 3; k++) begin
      irq_clear <= 10'h3ff;
      step(1);
      irq_clear <= 10'h000;
      if (k == 2) alarm_arm <= 4'h1;
      step(1);
      alarm_arm <= 4'h0;
      alarm_trig <= 4'h3;
      step(1);
      alarm_trig <= 4'h0;
      e = (k != 1);
      chk(irq_status[7:6], {1'b1, e}, "alarm irq");
      step(1);
      chk(pin_out[3:2], {1'b1, e}, "alarm on");
      step(2);
      chk(pin_out[3:2], {1'b1, e}, "alarm held");
      step(1);
      chk(pin_out[3:2], 2'b00, "alarm length");
    end
    summarize();
  end
endmodule
